// ---- logic/rmc_pkg.sv ----
package rmc_pkg;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int BASE_W = 32;
    localparam logic [31:0] MGMT_BASE_RESET = 32'h00030000;
    // reset pins read as asserted until really sampled, so the core
    // never runs a cycle between reset release and the first sample
    localparam logic [1:0] SYNC_RESET = 2'h3;
    localparam logic [1:0] IRQ_SYNC_RESET = 2'h3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int MIN_RESET_CLKS = 15;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SAVE,
        ST_HANDLER,
        ST_RESTORE
    } rmc_state_type;
endpackage

// ---- logic/rmc_sync_if.sv ----
`timescale 1ns/1ps
interface rmc_sync_if;
    logic hard_rst;
    logic soft_rst;
    logic irq_req_n;
    modport src (output hard_rst, output soft_rst, output irq_req_n);
    modport dst (input hard_rst, input soft_rst, input irq_req_n);
endinterface

// ---- logic/rmc_sync.sv ----
`timescale 1ns/1ps
module rmc_sync
    import rmc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // raw pins
    input wire logic hard_rst_pin,
    input wire logic soft_rst_pin,
    input wire logic irq_pin_n,
    // synchronised copies
    rmc_sync_if.src sy
);
    logic [1:0] hard_q;
    logic [1:0] soft_q;
    logic [1:0] irq_q;

    // ------------------------------------------------------------
    // two-stage synchronisers, stage 0 read only by stage 1
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hard_q <= SYNC_RESET;
            soft_q <= SYNC_RESET;
            irq_q <= IRQ_SYNC_RESET;
        end else if (ce) begin
            hard_q <= {hard_q[0], hard_rst_pin};
            soft_q <= {soft_q[0], soft_rst_pin};
            irq_q <= {irq_q[0], irq_pin_n};
        end
    end

    assign sy.hard_rst = hard_q[1];
    assign sy.soft_rst = soft_q[1];
    assign sy.irq_req_n = irq_q[1];
endmodule

// ---- logic/rmc_top.sv ----
`timescale 1ns/1ps
// Functional notes
// - hard reset aborts activity; execution restarts from the defined state.
// - hard reset is synchronised; recognised only once stable at an edge.
// - hard reset loads base pointer with 30000h.
// - soft reset acts as hard reset but keeps the base pointer.
// - soft reset is ignored while the upgrade-present input is asserted.
// - falling request edge enters management mode after current instruction.
// - pending request taken only on instruction boundary, each string iteration.
// - during handler no new entry; one further falling edge latched.
// - latched request acted on only after resume instruction completes.
// - active output goes low as state save begins.
// - active output stays low until last restore cycle, then released.
module rmc_top
    import rmc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    // board pins
    input wire logic hard_reset_in,
    input wire logic soft_reset_in,
    input wire logic upgrade_present_n,
    input wire logic mgmt_irq_req_n,
    output logic mgmt_active_out_n,
    // core status
    input wire logic insn_boundary,
    input wire logic locked_seq,
    input wire logic save_done,
    input wire logic resume_from_mgmt,
    input wire logic restore_last,
    input wire logic base_wr,
    input wire logic [BASE_W-1:0] base_wr_data,
    // core control
    output logic core_reset,
    output logic mgmt_entry,
    output logic mgmt_mode,
    output logic [BASE_W-1:0] mgmt_state_base_ptr
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    rmc_sync_if sy ();
    logic [1:0] up_q;
    logic up_n_s;

    rmc_sync u_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .ce(clk_en),
        .hard_rst_pin(hard_reset_in),
        .soft_rst_pin(soft_reset_in),
        .irq_pin_n(mgmt_irq_req_n),
        .sy(sy.src)
    );

    // upgrade-present is a board level, also synchronised
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 2'h3;
        end else if (clk_en) begin
            up_q <= {up_q[0], upgrade_present_n};
        end
    end
    assign up_n_s = up_q[1];

    // ------------------------------------------------------------
    // reset decode
    // ------------------------------------------------------------
    logic soft_eff;
    logic any_reset;

    assign soft_eff = sy.soft_rst & up_n_s;
    assign any_reset = sy.hard_rst | soft_eff;

    logic core_reset_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_reset_q <= 1'b1;
        end else if (clk_en) begin
            core_reset_q <= any_reset;
        end
    end
    assign core_reset = core_reset_q;

    // ------------------------------------------------------------
    // base pointer
    // ------------------------------------------------------------
    logic [BASE_W-1:0] base_q;
    logic [BASE_W-1:0] base_d;

    assign base_d = sy.hard_rst ? MGMT_BASE_RESET :
                    (base_wr && !soft_eff) ? base_wr_data : base_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            base_q <= MGMT_BASE_RESET;
        end else if (clk_en) begin
            base_q <= base_d;
        end
    end
    assign mgmt_state_base_ptr = base_q;

    // ------------------------------------------------------------
    // request edge detect
    // ------------------------------------------------------------
    logic irq_prev_q;
    logic irq_fall;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_prev_q <= 1'b1;
        end else if (clk_en) begin
            irq_prev_q <= sy.irq_req_n;
        end
    end
    assign irq_fall = irq_prev_q & ~sy.irq_req_n;

    // ------------------------------------------------------------
    // management state machine
    // ------------------------------------------------------------
    rmc_state_type state_q;
    rmc_state_type state_d;
    logic pend_q;
    logic pend_d;
    logic take;
    logic active_n_q;
    logic active_n_d;

    assign take = pend_q & insn_boundary & ~locked_seq;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (take) begin
                    state_d = ST_SAVE;
                end
            end
            ST_SAVE: begin
                if (save_done) begin
                    state_d = ST_HANDLER;
                end
            end
            ST_HANDLER: begin
                if (resume_from_mgmt) begin
                    state_d = ST_RESTORE;
                end
            end
            ST_RESTORE: begin
                if (restore_last) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // latch one pending edge; new edge wins over consume
    assign pend_d = irq_fall ? 1'b1 :
                    (state_q == ST_RUN && take) ? 1'b0 : pend_q;

    assign active_n_d = (state_d == ST_RUN);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
            pend_q <= 1'b0;
            active_n_q <= 1'b1;
        end else if (clk_en) begin
            if (any_reset) begin
                state_q <= ST_RUN;
                pend_q <= 1'b0;
                active_n_q <= 1'b1;
            end else begin
                state_q <= state_d;
                pend_q <= pend_d;
                active_n_q <= active_n_d;
            end
        end
    end

    logic entry_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            entry_q <= 1'b0;
        end else if (clk_en) begin
            entry_q <= ~any_reset & (state_q == ST_RUN) & take;
        end
    end

    assign mgmt_entry = entry_q;
    assign mgmt_mode = ~active_n_q;
    assign mgmt_active_out_n = active_n_q;
endmodule

// ---- testbench/rmc_core_model.sv ----
`timescale 1ns/1ps
module rmc_core_model (
    // clock
    input wire logic clk,
    // core handshake
    input wire logic mgmt_entry,
    input wire logic [3:0] dly,
    output logic insn_boundary,
    output logic save_done,
    output logic resume_from_mgmt,
    output logic restore_last
);
    logic [2:0] pulse_q = 3'h0;
    logic [1:0] ph_q = 2'h0;
    // sparse boundaries, so an entry has to wait for one
    assign insn_boundary = (ph_q == 2'h0);
    assign {restore_last, resume_from_mgmt, save_done} = pulse_q;
    always @(posedge clk) ph_q <= ph_q + 2'h1;
    task automatic pulse(input int k);
        repeat (dly) @(posedge clk);
        #1 pulse_q = 3'h1 << k;
        @(posedge clk);
        #1 pulse_q = 3'h0;
    endtask
    // save, resume, then last restore; dly sets prompt or slow
    initial forever begin
        @(posedge clk);
        #1;
        if (mgmt_entry === 1'b1) begin
            for (int k = 0; k < 3; k++) pulse(k);
        end
    end
endmodule

// ---- testbench/rmc_top_props.sv ----
`timescale 1ns/1ps
module rmc_top_props
    import rmc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    // inputs watched
    input wire logic hard_reset_in,
    input wire logic soft_reset_in,
    input wire logic upgrade_present_n,
    input wire logic insn_boundary,
    input wire logic locked_seq,
    input wire logic restore_last,
    input wire logic base_wr,
    // outputs watched
    input wire logic mgmt_active_out_n,
    input wire logic core_reset,
    input wire logic mgmt_entry,
    input wire logic mgmt_mode,
    input wire logic [BASE_W-1:0] mgmt_state_base_ptr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    hard_take_a: assert property (
        (hard_reset_in && clk_en)[*4] |=> core_reset) else $error("hard");
    base_load_a: assert property ((hard_reset_in && clk_en)[*4] |=>
        mgmt_state_base_ptr == MGMT_BASE_RESET) else $error("base load");
    soft_take_a: assert property (
        (soft_reset_in && upgrade_present_n && clk_en)[*4] |=> core_reset)
        else $error("soft");
    soft_block_a: assert property (
        (!hard_reset_in && !upgrade_present_n && clk_en)[*8] |=> !core_reset)
        else $error("soft not blocked");
    base_keep_a: assert property ((!hard_reset_in && !base_wr)[*5] |=>
        $stable(mgmt_state_base_ptr)) else $error("base moved");
    entry_gate_a: assert property (mgmt_entry |->
        $past(insn_boundary) && !$past(locked_seq)) else $error("gate");
    no_nest_a: assert property (!$past(mgmt_active_out_n) |->
        !mgmt_entry) else $error("nested entry");
    act_low_a: assert property ($fell(mgmt_active_out_n) |->
        mgmt_entry && mgmt_mode) else $error("active low");
    act_hold_a: assert property ($rose(mgmt_active_out_n) |->
        $past(restore_last) || core_reset) else $error("early release");
    act_free_a: assert property (restore_last && !mgmt_active_out_n |=>
        mgmt_active_out_n) else $error("no release");
endmodule
bind rmc_top rmc_top_props i_rmc_top_props (.mclk, .arst_n, .clk_en,
    .hard_reset_in, .soft_reset_in, .upgrade_present_n, .insn_boundary,
    .locked_seq, .restore_last, .base_wr, .mgmt_active_out_n, .core_reset,
    .mgmt_entry, .mgmt_mode, .mgmt_state_base_ptr);

// ---- testbench/rmc_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR %0t %h %h", $time, (a), (e)); end end
module rmc_tb_top
    import rmc_pkg::*;
;
    logic mclk, arst_n, clk_en, hard_reset_in, soft_reset_in;
    logic upgrade_present_n, mgmt_irq_req_n, mgmt_active_out_n;
    logic insn_boundary, locked_seq, save_done, resume_from_mgmt;
    logic restore_last, base_wr, core_reset, mgmt_entry, mgmt_mode;
    logic [BASE_W-1:0] base_wr_data, mgmt_state_base_ptr;
    logic [3:0] dly;
    int bad_count, cmp_count;
    bit hit;
    rmc_top i_rmc_top (.mclk, .arst_n, .clk_en, .hard_reset_in,
        .soft_reset_in, .upgrade_present_n, .mgmt_irq_req_n,
        .mgmt_active_out_n, .insn_boundary, .locked_seq, .save_done,
        .resume_from_mgmt, .restore_last, .base_wr, .base_wr_data,
        .core_reset, .mgmt_entry, .mgmt_mode, .mgmt_state_base_ptr);
    rmc_core_model i_rmc_core_model (.clk(mclk), .mgmt_entry, .dly,
        .insn_boundary, .save_done, .resume_from_mgmt, .restore_last);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // sel 0: entry strobe, sel 1: active output released
    task automatic wait_for(input bit sel, input int n);
        hit = 0;
        for (int i = 0; i < n && !hit; i++) begin
            step(1);
            hit = sel ? mgmt_active_out_n === 1'b1 : mgmt_entry === 1'b1;
        end
    endtask
    task automatic t_resets();
        // frozen: neither a reset pin nor the write strobe may land
        clk_en = 1'b0;
        hard_reset_in = 1'b1;
        base_wr = 1'b1;
        base_wr_data = 32'h00041000;
        step(8);
        `CHK(core_reset, 1'b0)
        `CHK(mgmt_state_base_ptr, MGMT_BASE_RESET)
        clk_en = 1'b1;
        hard_reset_in = 1'b0;
        step(1);
        base_wr = 1'b0;
        soft_reset_in = 1'b1;
        step(8);
        `CHK(core_reset, 1'b1)
        step(8);
        soft_reset_in = 1'b0;
        step(8);
        `CHK(mgmt_state_base_ptr, 32'h00041000)
        upgrade_present_n = 1'b0;
        soft_reset_in = 1'b1;
        step(16);
        `CHK(core_reset, 1'b0)
        soft_reset_in = 1'b0;
        upgrade_present_n = 1'b1;
        hard_reset_in = 1'b1;
        step(2);
        `CHK(core_reset, 1'b0)
        step(14);
        `CHK(mgmt_state_base_ptr, MGMT_BASE_RESET)
        hard_reset_in = 1'b0;
        step(8);
        `CHK(core_reset, 1'b0)
    endtask
    task automatic t_smi();
        mgmt_irq_req_n = 1'b0;
        wait_for(0, 20);
        `CHK(hit, 1'b1)
        `CHK(mgmt_active_out_n, 1'b0)
        `CHK(mgmt_mode, 1'b1)
        // two edges inside the handler must merge into one
        repeat (2) begin
            mgmt_irq_req_n = 1'b1;
            step(1);
            mgmt_irq_req_n = 1'b0;
            step(1);
        end
        wait_for(1, 60);
        `CHK(hit, 1'b1)
        wait_for(0, 20);
        `CHK(hit, 1'b1)
        wait_for(1, 60);
        wait_for(0, 30);
        `CHK(hit, 1'b0)
        mgmt_irq_req_n = 1'b1;
        step(4);
    endtask
    task automatic t_lock();
        locked_seq = 1'b1;
        mgmt_irq_req_n = 1'b0;
        wait_for(0, 20);
        `CHK(hit, 1'b0)
        locked_seq = 1'b0;
        wait_for(0, 10);
        `CHK(hit, 1'b1)
        wait_for(1, 60);
        mgmt_irq_req_n = 1'b1;
        step(4);
    endtask
    task automatic t_abort();
        mgmt_irq_req_n = 1'b0;
        wait_for(0, 20);
        step(2);
        hard_reset_in = 1'b1;
        step(16);
        `CHK(mgmt_active_out_n, 1'b1)
        `CHK(core_reset, 1'b1)
        hard_reset_in = 1'b0;
        mgmt_irq_req_n = 1'b1;
        step(8);
    endtask
    task automatic complete_run();
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // the whole sequence needs well under 2000 clocks
    initial begin
        #40000;
        bad_count++;
        complete_run();
    end
    initial begin
        {arst_n, soft_reset_in, locked_seq, base_wr} = 4'h0;
        {clk_en, upgrade_present_n, mgmt_irq_req_n, hard_reset_in} = 4'hf;
        base_wr_data = '0;
        dly = 4'h3;
        step(10);
        arst_n = 1'b1;
        // hard reset held past release; 1 ms would blow the budget
        step(4);
        `CHK(core_reset, 1'b1)
        step(6);
        hard_reset_in = 1'b0;
        step(10);
        `CHK(core_reset, 1'b0)
        `CHK(mgmt_state_base_ptr, MGMT_BASE_RESET)
        t_resets();
        t_smi();
        dly = 4'h8;
        t_smi();
        t_lock();
        t_abort();
        complete_run();
    end
endmodule
